// File: rtl/flsq_defs.svh
// Constants of the flash sequencer host: register map, fields, flash codes, timing.
// Assumes inclusion by bare name from the design files.
`ifndef FLSQ_DEFS_SVH
`define FLSQ_DEFS_SVH
// Register offsets
`define FLSQ_REG_CMD    3'h0
`define FLSQ_REG_ADDR   3'h1
`define FLSQ_REG_DATA   3'h2
`define FLSQ_REG_CFG    3'h3
`define FLSQ_REG_STAT   3'h4
`define FLSQ_REG_POLL   3'h5
// Field positions and reset values
`define FLSQ_CFG_BYTE   0
`define FLSQ_CFG_RST    1'b0
`define FLSQ_ST_CBUSY   0
`define FLSQ_ST_FBUSY   1
`define FLSQ_ST_SECURE  2
`define FLSQ_ST_BYPASS  3
`define FLSQ_ST_WINDOW  4
`define FLSQ_ST_REFUSED 5
`define FLSQ_ST_PVALID  6
`define FLSQ_ST_POLL    7
`define FLSQ_ST_TOGGLE  8
`define FLSQ_ST_ETOGGLE 9
`define FLSQ_ST_EWIN    10
`define FLSQ_ST_TOUT    11
// Polled flash status bits
`define FLSQ_DQ_POLL    7
`define FLSQ_DQ_TOGGLE  6
`define FLSQ_DQ_TOUT    5
`define FLSQ_DQ_EWIN    3
`define FLSQ_DQ_ETOGGLE 2
// Operation codes written to the command register
`define FLSQ_OP_READ    4'h1
`define FLSQ_OP_PROG    4'h2
`define FLSQ_OP_CHIP    4'h3
`define FLSQ_OP_SECT    4'h4
`define FLSQ_OP_SADD    4'h5
`define FLSQ_OP_RESET   4'h6
`define FLSQ_OP_HWRST   4'h7
`define FLSQ_OP_SSIN    4'h8
`define FLSQ_OP_SSOUT   4'h9
`define FLSQ_OP_BYPIN   4'hA
`define FLSQ_OP_BYPOUT  4'hB
// Unlock addresses, word and byte mode
`define FLSQ_A1_WORD    12'h555
`define FLSQ_A2_WORD    12'h2AA
`define FLSQ_A1_BYTE    12'hAAA
`define FLSQ_A2_BYTE    12'h555
// Flash command data
`define FLSQ_D_UNLK1    8'hAA
`define FLSQ_D_UNLK2    8'h55
`define FLSQ_D_SSIN     8'h88
`define FLSQ_D_EXIT     8'h90
`define FLSQ_D_ZERO     8'h00
`define FLSQ_D_PROG     8'hA0
`define FLSQ_D_BYP      8'h20
`define FLSQ_D_ESET     8'h80
`define FLSQ_D_CHIP     8'h10
`define FLSQ_D_SECT     8'h30
`define FLSQ_D_RST      8'hF0
// Timing
`define FLSQ_CLK_MHZ    25
`define FLSQ_WIN_US     50
`define FLSQ_WIN_CYC    (`FLSQ_WIN_US * `FLSQ_CLK_MHZ)
`endif

// File: rtl/flsq_pkg.sv
// Types shared by the flash sequencer host modules.
// Assumes no other package.
package flsq_pkg;
	typedef enum logic [1:0] {FLSQ_IDLE, FLSQ_ISSUE, FLSQ_WAIT, FLSQ_HWRST} flsq_host_st_e;
	typedef enum logic [1:0] {FLSQ_B_IDLE, FLSQ_B_SETUP, FLSQ_B_PULSE, FLSQ_B_HOLD} flsq_bus_st_e;
endpackage

// File: rtl/flsq_bus_cycle.sv
// One asynchronous flash bus cycle, write or read, on registered pins.
// Assumes a start only while idle; pins are synchronous to clock_i.
`timescale 1ns/100ps
`include "flsq_defs.svh"
module flsq_bus_cycle #(
	parameter int AW         = 20,
	parameter int DW         = 16,
	parameter int WE_LOW_CYC = 2,
	parameter int RD_CYC     = 3
) (
	// Clock and reset
	input  wire logic          clock_i,
	input  wire logic          rstn_i,
	input  wire logic          ce_i,
	// Request
	input  wire logic          start_i,
	input  wire logic          read_i,
	input  wire logic [AW-1:0] addr_i,
	input  wire logic [DW-1:0] data_i,
	output logic               done_o,
	output logic [DW-1:0]      q_o,
	// Flash pins
	output logic [AW-1:0]      addr_o,
	input  wire logic [DW-1:0] dq_i,
	output logic [DW-1:0]      dq_o,
	output logic               dq_oe_o,
	output logic               ce_n_o,
	output logic               we_n_o,
	output logic               oe_n_o
);
	typedef struct packed {
		flsq_pkg::flsq_bus_st_e st;
		logic [3:0]             cnt;
		logic                   rd;
		logic [AW-1:0]          a;
		logic [DW-1:0]          d;
		logic                   oe;
		logic                   ce_n;
		logic                   we_n;
		logic                   oe_n;
		logic                   done;
		logic [DW-1:0]          q;
	} flsq_bus_s;
	flsq_bus_s s, next_s;

	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		unique case (s.st)
			flsq_pkg::FLSQ_B_IDLE: if (start_i) begin
				// Address and data settle before the write strobe falls; the read strobe falls with them
				next_s.a = addr_i; // R23
				next_s.d = data_i;
				next_s.rd = read_i;
				next_s.oe = !read_i;
				next_s.ce_n = 1'b0;
				next_s.oe_n = !read_i;
				next_s.st = flsq_pkg::FLSQ_B_SETUP;
			end
			flsq_pkg::FLSQ_B_SETUP: begin
				next_s.cnt = s.rd ? 4'(RD_CYC - 1) : 4'(WE_LOW_CYC - 1);
				next_s.we_n = s.rd;
				next_s.st = flsq_pkg::FLSQ_B_PULSE;
			end
			flsq_pkg::FLSQ_B_PULSE: if (s.cnt == 4'h0) begin
				if (s.rd) begin
					next_s.q = dq_i;
					next_s.oe_n = 1'b1;
				end
				// Write strobe rises first, chip select a cycle later
				next_s.we_n = 1'b1; // R23
				next_s.st = flsq_pkg::FLSQ_B_HOLD;
			end else begin
				next_s.cnt = s.cnt - 4'h1;
			end
			flsq_pkg::FLSQ_B_HOLD: begin
				next_s.ce_n = 1'b1;
				next_s.oe = 1'b0;
				next_s.done = 1'b1;
				next_s.st = flsq_pkg::FLSQ_B_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s <= '0;
			s.ce_n <= 1'b1;
			s.we_n <= 1'b1;
			s.oe_n <= 1'b1;
		end else if (ce_i) begin
			s <= next_s;
		end
	end

	assign done_o  = s.done;
	assign q_o     = s.q;
	assign addr_o  = s.a;
	assign dq_o    = s.d;
	assign dq_oe_o = s.oe;
	assign ce_n_o  = s.ce_n;
	assign we_n_o  = s.we_n;
	assign oe_n_o  = s.oe_n;

	default clocking @(posedge clock_i); endclocking
	default disable iff (!rstn_i);
	sequence write_cyc;
		!ce_n_o && we_n_o && dq_oe_o ##1 !we_n_o && !ce_n_o;
	endsequence
	wr_shape_a: assert property (ce_i && start_i && !read_i && s.st == flsq_pkg::FLSQ_B_IDLE |=> write_cyc) // R23
		else $error("write cycle strobes out of order");
	wr_latch_a: assert property ($rose(we_n_o) && dq_oe_o |-> !ce_n_o && $stable(dq_o) && $stable(addr_o)) // R23
		else $error("data moved at write strobe rise");
	cyc_done_a: assert property (ce_i && start_i && s.st == flsq_pkg::FLSQ_B_IDLE |-> ##[3:40] done_o)
		else $error("bus cycle did not finish");
endmodule

// File: rtl/flsq_host.sv
// Host-side command sequencer driving a parallel NOR flash over its pins.
// Assumes a register-port master; flash pins are synchronous to clock_i.
// Summary of operation
// R1: Secured region entered by three-write sequence
// R2: Four-write exit sequence restores normal array
// R3: No unlock bypass while secured region selected
// R4: Byte-width select picks word or byte programming
// R5: Program is four writes, last starts algorithm
// R6: Program completion returns device to array read
// R7: Commands during embedded program are ignored
// R8: Hardware reset aborts; reissue after array read
// R9: Programming only clears bits, any order
// R10: Bypass entry is two unlocks plus 20h
// R11: Bypass program is A0h then address/data
// R12: Bypass accepts only bypass program and reset
// R13: Bypass exit is 90h then 00h
// R14: Chip erase is six writes
// R15: Embedded erase preprograms by itself
// R16: Commands during chip erase are ignored
// R17: Erase progress on status bits and ready
// R18: Sector erase is six writes, sector last
// R19: 50 us add window from final strobe
// R20: Added sectors spaced under 50 us
// R21: Other command in window cancels erase
// R22: Window flag exposed; erasing takes only suspend
// R23: Address at later fall, data earlier rise
// R24: Reset command mid-sequence abandons it
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`include "flsq_defs.svh"
module flsq_host #(
	parameter int AW         = 20,
	parameter int DW         = 16,
	parameter int RST_CYC    = 13,
	parameter int GUARD_CYC  = 4,
	parameter int WE_LOW_CYC = 2,
	parameter int RD_CYC     = 3,
	parameter int WIN_CYC    = `FLSQ_WIN_CYC
) (
	// Clock and reset
	input  wire logic          clock_i,
	input  wire logic          rstn_i,
	input  wire logic          ce_i,
	// Register port
	input  wire logic [2:0]    reg_addr_i,
	input  wire logic [31:0]   reg_wdata_i,
	input  wire logic          reg_wr_i,
	input  wire logic          reg_rd_i,
	output logic [31:0]        reg_rdata_o,
	// Flash pins
	output logic [AW-1:0]      flash_addr_o,
	input  wire logic [DW-1:0] flash_dq_i,
	output logic [DW-1:0]      flash_dq_o,
	output logic               flash_dq_oe_o,
	output logic               flash_ce_n_o,
	output logic               flash_we_n_o,
	output logic               flash_oe_n_o,
	output logic               flash_byte_n_o,
	output logic               flash_reset_n_o,
	input  wire logic          ready_busy_i
);
	localparam int WW = $clog2(WIN_CYC + 1);
	// Margin so an added sector write still ends inside the window
	localparam int WIN_LAST = WIN_CYC - WE_LOW_CYC - 6;

	typedef struct packed {
		flsq_pkg::flsq_host_st_e st;
		logic [3:0]              op;
		logic [2:0]              step;
		logic [2:0]              last;
		logic [AW-1:0]           addr;
		logic [DW-1:0]           data;
		logic                    byte_mode;
		logic                    secured;
		logic                    bypass;
		logic                    refused;
		logic                    poll_valid;
		logic                    win_open;
		logic [WW-1:0]           win_cnt;
		logic [7:0]              wait_cnt;
		logic                    go;
		logic                    go_rd;
		logic [AW-1:0]           go_a;
		logic [DW-1:0]           go_d;
		logic [DW-1:0]           poll;
		logic                    reset_n;
		logic [31:0]             rdata;
	} flsq_host_s;
	flsq_host_s s, next_s;

	logic [1:0]    rst_sync;
	logic          rst_n;
	logic          bus_done;
	logic [DW-1:0] bus_q;
	logic          fbusy;
	logic          ok;
	logic          acc;
	logic [31:0]   stat;

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	function automatic logic [2:0] op_len(input logic [3:0] op, input logic byp);
		case (op)
			`FLSQ_OP_PROG: op_len = byp ? 3'd2 : 3'd4; // R5 R11
			`FLSQ_OP_CHIP, `FLSQ_OP_SECT: op_len = 3'd6; // R14 R18
			`FLSQ_OP_SSIN, `FLSQ_OP_BYPIN: op_len = 3'd3; // R1 R10
			`FLSQ_OP_SSOUT: op_len = 3'd4; // R2
			`FLSQ_OP_BYPOUT: op_len = 3'd2; // R13
			default: op_len = 3'd1;
		endcase
	endfunction

	// Address and data of write i of an operation
	function automatic logic [AW+DW-1:0] step_word(input logic [3:0] op, input logic [2:0] i, input logic byp,
		input logic bm, input logic [AW-1:0] a, input logic [DW-1:0] d);
		logic [AW-1:0] u1;
		logic [AW-1:0] u2;
		logic [7:0]    c3;
		u1 = bm ? AW'(`FLSQ_A1_BYTE) : AW'(`FLSQ_A1_WORD);
		u2 = bm ? AW'(`FLSQ_A2_BYTE) : AW'(`FLSQ_A2_WORD);
		case (op)
			`FLSQ_OP_SSIN: c3 = `FLSQ_D_SSIN;
			`FLSQ_OP_SSOUT: c3 = `FLSQ_D_EXIT;
			`FLSQ_OP_BYPIN: c3 = `FLSQ_D_BYP;
			`FLSQ_OP_PROG: c3 = `FLSQ_D_PROG;
			default: c3 = `FLSQ_D_ESET;
		endcase
		step_word = {a, d};
		case (op)
			`FLSQ_OP_READ: step_word = {a, d};
			`FLSQ_OP_SADD: step_word = {a, DW'(`FLSQ_D_SECT)}; // R19
			`FLSQ_OP_RESET: step_word = {a, DW'(`FLSQ_D_RST)}; // R24
			`FLSQ_OP_BYPOUT: step_word = {a, (i == 3'd0) ? DW'(`FLSQ_D_EXIT) : DW'(`FLSQ_D_ZERO)}; // R13
			default: if (op == `FLSQ_OP_PROG && byp) begin
				step_word = (i == 3'd0) ? {a, DW'(`FLSQ_D_PROG)} : {a, d}; // R11
			end else begin
				case (i)
					3'd0: step_word = {u1, DW'(`FLSQ_D_UNLK1)};
					3'd1: step_word = {u2, DW'(`FLSQ_D_UNLK2)};
					3'd2: step_word = {u1, DW'(c3)}; // R1 R10
					3'd3: if (op == `FLSQ_OP_SSOUT) begin
						step_word = {a, DW'(`FLSQ_D_ZERO)}; // R2
					end else if (op == `FLSQ_OP_PROG) begin
						step_word = {a, d}; // R5
					end else begin
						step_word = {u1, DW'(`FLSQ_D_UNLK1)};
					end
					3'd4: step_word = {u2, DW'(`FLSQ_D_UNLK2)};
					default: step_word = (op == `FLSQ_OP_CHIP) ? {u1, DW'(`FLSQ_D_CHIP)} : {a, DW'(`FLSQ_D_SECT)}; // R14 R18
				endcase
			end
		endcase
	endfunction

	always_comb begin
		next_s = s;
		next_s.go = 1'b0;
		next_s.rdata = 32'h0000_0000;
		// Guard covers the gap before the flash pulls its busy line
		fbusy = !ready_busy_i || s.wait_cnt != 8'h00; // R7 R16 R22
		case (reg_wdata_i[3:0])
			`FLSQ_OP_READ, `FLSQ_OP_HWRST: ok = 1'b1; // R8 R17
			`FLSQ_OP_PROG: ok = !fbusy && !s.win_open; // R7
			`FLSQ_OP_CHIP, `FLSQ_OP_SECT, `FLSQ_OP_SSIN, `FLSQ_OP_SSOUT: ok = !fbusy && !s.bypass && !s.win_open; // R12
			`FLSQ_OP_SADD: ok = s.win_open && s.win_cnt < WW'(WIN_LAST); // R20
			`FLSQ_OP_RESET: ok = !s.bypass && (!fbusy || s.win_open); // R21 R24
			`FLSQ_OP_BYPIN: ok = !fbusy && !s.bypass && !s.secured && !s.win_open; // R3
			`FLSQ_OP_BYPOUT: ok = s.bypass && !fbusy; // R12
			default: ok = 1'b0;
		endcase
		acc = reg_wr_i && reg_addr_i == `FLSQ_REG_CMD && s.st == flsq_pkg::FLSQ_IDLE && ok;
		if (s.wait_cnt != 8'h00) begin
			next_s.wait_cnt = s.wait_cnt - 8'h01;
		end
		if (s.win_open) begin
			if (s.win_cnt == WW'(WIN_CYC - 1)) begin
				next_s.win_open = 1'b0; // R19
			end else begin
				next_s.win_cnt = s.win_cnt + WW'(1);
			end
		end
		if (reg_wr_i) begin
			case (reg_addr_i)
				// Operands are frozen while a sequence runs
				`FLSQ_REG_ADDR: if (s.st == flsq_pkg::FLSQ_IDLE) next_s.addr = reg_wdata_i[AW-1:0];
				`FLSQ_REG_DATA: if (s.st == flsq_pkg::FLSQ_IDLE) next_s.data = reg_wdata_i[DW-1:0];
				`FLSQ_REG_CFG: next_s.byte_mode = reg_wdata_i[`FLSQ_CFG_BYTE]; // R4
				`FLSQ_REG_CMD: begin
					next_s.refused = !acc;
					if (acc) begin
						next_s.op = reg_wdata_i[3:0];
						next_s.step = 3'd0;
						next_s.last = op_len(reg_wdata_i[3:0], s.bypass) - 3'd1;
						if (reg_wdata_i[3:0] == `FLSQ_OP_HWRST) begin
							next_s.reset_n = 1'b0; // R8
							next_s.wait_cnt = 8'(RST_CYC);
							next_s.st = flsq_pkg::FLSQ_HWRST;
						end else begin
							next_s.st = flsq_pkg::FLSQ_ISSUE;
						end
					end
				end
				default: ;
			endcase
		end
		stat = 32'h0000_0000;
		stat[`FLSQ_ST_CBUSY] = s.st != flsq_pkg::FLSQ_IDLE;
		stat[`FLSQ_ST_FBUSY] = !ready_busy_i; // R6 R17
		stat[`FLSQ_ST_SECURE] = s.secured;
		stat[`FLSQ_ST_BYPASS] = s.bypass;
		stat[`FLSQ_ST_WINDOW] = s.win_open;
		stat[`FLSQ_ST_REFUSED] = s.refused;
		stat[`FLSQ_ST_PVALID] = s.poll_valid;
		stat[`FLSQ_ST_POLL] = s.poll[`FLSQ_DQ_POLL]; // R17
		stat[`FLSQ_ST_TOGGLE] = s.poll[`FLSQ_DQ_TOGGLE];
		stat[`FLSQ_ST_ETOGGLE] = s.poll[`FLSQ_DQ_ETOGGLE];
		stat[`FLSQ_ST_EWIN] = s.poll[`FLSQ_DQ_EWIN]; // R22
		stat[`FLSQ_ST_TOUT] = s.poll[`FLSQ_DQ_TOUT];
		if (reg_rd_i) begin
			case (reg_addr_i)
				`FLSQ_REG_CMD: next_s.rdata = 32'(s.op);
				`FLSQ_REG_ADDR: next_s.rdata = 32'(s.addr);
				`FLSQ_REG_DATA: next_s.rdata = 32'(s.data);
				`FLSQ_REG_CFG: next_s.rdata = 32'(s.byte_mode);
				`FLSQ_REG_STAT: next_s.rdata = stat;
				`FLSQ_REG_POLL: next_s.rdata = 32'(s.poll);
				default: next_s.rdata = 32'h0000_0000;
			endcase
		end
		unique case (s.st)
			flsq_pkg::FLSQ_IDLE: ;
			flsq_pkg::FLSQ_ISSUE: begin
				next_s.go = 1'b1;
				next_s.go_rd = s.op == `FLSQ_OP_READ;
				{next_s.go_a, next_s.go_d} = step_word(s.op, s.step, s.bypass, s.byte_mode, s.addr, s.data);
				next_s.st = flsq_pkg::FLSQ_WAIT;
			end
			flsq_pkg::FLSQ_WAIT: if (bus_done) begin
				if (s.op == `FLSQ_OP_READ) begin
					next_s.poll = bus_q;
					next_s.poll_valid = 1'b1;
				end
				if (s.step == s.last) begin
					next_s.st = flsq_pkg::FLSQ_IDLE;
					case (s.op)
						`FLSQ_OP_SSIN: next_s.secured = 1'b1; // R1
						`FLSQ_OP_SSOUT: next_s.secured = 1'b0; // R2
						`FLSQ_OP_BYPIN: next_s.bypass = 1'b1; // R10
						`FLSQ_OP_BYPOUT: next_s.bypass = 1'b0; // R13
						`FLSQ_OP_PROG, `FLSQ_OP_CHIP: next_s.wait_cnt = 8'(GUARD_CYC); // R7 R16
						`FLSQ_OP_SECT, `FLSQ_OP_SADD: begin
							next_s.win_open = 1'b1; // R19
							next_s.win_cnt = '0;
							next_s.wait_cnt = 8'(GUARD_CYC);
						end
						`FLSQ_OP_RESET: next_s.win_open = 1'b0; // R21 R24
						default: ;
					endcase
				end else begin
					next_s.step = s.step + 3'd1;
					next_s.st = flsq_pkg::FLSQ_ISSUE;
				end
			end
			flsq_pkg::FLSQ_HWRST: if (s.wait_cnt == 8'h00) begin
				// Device drops every mode; the caller reissues aborted work
				next_s.reset_n = 1'b1; // R8
				next_s.secured = 1'b0;
				next_s.bypass = 1'b0;
				next_s.win_open = 1'b0;
				next_s.wait_cnt = 8'(GUARD_CYC);
				next_s.st = flsq_pkg::FLSQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.reset_n <= 1'b1;
		end else if (ce_i) begin
			s <= next_s;
		end
	end

	flsq_bus_cycle #(
		.AW         (AW),
		.DW         (DW),
		.WE_LOW_CYC (WE_LOW_CYC),
		.RD_CYC     (RD_CYC)
	) u_bus (
		.clock_i (clock_i),
		.rstn_i  (rst_n),
		.ce_i    (ce_i),
		.start_i (s.go),
		.read_i  (s.go_rd),
		.addr_i  (s.go_a),
		.data_i  (s.go_d),
		.done_o  (bus_done),
		.q_o     (bus_q),
		.addr_o  (flash_addr_o),
		.dq_i    (flash_dq_i),
		.dq_o    (flash_dq_o),
		.dq_oe_o (flash_dq_oe_o),
		.ce_n_o  (flash_ce_n_o),
		.we_n_o  (flash_we_n_o),
		.oe_n_o  (flash_oe_n_o)
	);

	assign reg_rdata_o     = s.rdata;
	assign flash_byte_n_o  = !s.byte_mode; // R4
	assign flash_reset_n_o = s.reset_n;

	// Write strobes counted per operation, independent of the step counter
	logic       we_q;
	logic [3:0] wcnt;
	logic       fin;
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			we_q <= 1'b1;
			wcnt <= 4'h0;
		end else if (ce_i) begin
			we_q <= flash_we_n_o;
			if (s.st == flsq_pkg::FLSQ_IDLE) begin
				wcnt <= 4'h0;
			end else if (we_q && !flash_we_n_o) begin
				wcnt <= wcnt + 4'h1;
			end
		end
	end
	assign fin = ce_i && s.st == flsq_pkg::FLSQ_WAIT && bus_done && s.step == s.last;

	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n);
	ss_enter_len_a: assert property (fin && s.op == `FLSQ_OP_SSIN |-> wcnt == 4'd3 ##1 s.secured) // R1
		else $error("secured entry not three writes");
	ss_exit_len_a: assert property (fin && s.op == `FLSQ_OP_SSOUT |-> wcnt == 4'd4 ##1 !s.secured) // R2
		else $error("secured exit not four writes");
	prog_len_a: assert property (fin && s.op == `FLSQ_OP_PROG && !s.bypass |-> wcnt == 4'd4) // R5
		else $error("program not four writes");
	byp_enter_len_a: assert property (fin && s.op == `FLSQ_OP_BYPIN |-> wcnt == 4'd3 && s.go_d[7:0] == 8'h20) // R10
		else $error("bypass entry malformed");
	byp_prog_len_a: assert property (fin && s.op == `FLSQ_OP_PROG && s.bypass |-> wcnt == 4'd2) // R11
		else $error("bypass program not two writes");
	byp_exit_len_a: assert property (fin && s.op == `FLSQ_OP_BYPOUT |-> wcnt == 4'd2 ##1 !s.bypass) // R13
		else $error("bypass exit malformed");
	chip_len_a: assert property (fin && s.op == `FLSQ_OP_CHIP |-> wcnt == 4'd6 && s.go_d[7:0] == 8'h10) // R14
		else $error("chip erase not six writes");
	sect_len_a: assert property (fin && s.op == `FLSQ_OP_SECT |-> wcnt == 4'd6 ##1 s.win_open) // R18
		else $error("sector erase not six writes");
	reset_len_a: assert property (fin && s.op == `FLSQ_OP_RESET |-> wcnt == 4'd1 ##1 !s.win_open) // R24
		else $error("reset command malformed");
	no_byp_secure_a: assert property (!(s.secured && s.bypass)) // R3
		else $error("bypass while secured");
	sadd_window_a: assert property (acc && reg_wdata_i[3:0] == `FLSQ_OP_SADD |-> s.win_open) // R20
		else $error("sector added outside window");
	hw_reset_a: assert property ($rose(flash_reset_n_o) |-> !s.bypass && !s.secured && !s.win_open) // R8
		else $error("modes kept over hardware reset");
endmodule

// File: verif/flsq_flash_model.sv
// Behavioural parallel flash for the host bench: logs writes, busy timer, sector window.
// Assumes host pins registered on clock_i; writes strobed by ce_n and we_n.
`timescale 1ns/100ps
module flsq_flash_model #(
	parameter int PROG_CYC  = 20,
	parameter int ERASE_CYC = 60,
	parameter int WINM      = 200
) (
	// Timer clock
	input  wire logic        clock_i,
	// Flash pins
	input  wire logic [19:0] addr_i,
	input  wire logic [15:0] dq_i,
	input  wire logic        dq_oe_i,
	output logic [15:0]      dq_o,
	input  wire logic        ce_n_i,
	input  wire logic        we_n_i,
	input  wire logic        oe_n_i,
	input  wire logic        reset_n_i,
	output logic             ready_busy_o
);
	logic [11:0] la [0:127];
	logic [7:0]  ld [0:127];
	int          n        = 0;
	int          bc       = 0;
	int          wc       = 0;
	logic        act      = 1'b0;
	logic        tog      = 1'b0;
	logic        rst_seen = 1'b0;
	logic [19:0] lat;
	logic [7:0]  d;
	logic [7:0]  prev     = 8'h00;
	logic [15:0] last     = 16'h0000;
	logic [15:0] rv;
	assign ready_busy_o = (bc == 0);
	// Status while busy, low address bits as array data when ready
	always @* rv = (bc != 0) ? {9'h000, tog, 6'h00} : addr_i[15:0];
	// Released bus shows the inverse, not a stale value
	assign dq_o = (!ce_n_i && !oe_n_i) ? rv : ~last;
	always @(posedge oe_n_i) begin
		last = rv;
		tog = ~tog;
	end
	always @(negedge we_n_i or negedge ce_n_i)
		if (!we_n_i && !ce_n_i && oe_n_i) begin
			lat = addr_i;
			act = 1'b1;
		end
	always @(posedge we_n_i or posedge ce_n_i)
		if (act) begin
			act = 1'b0;
			d = dq_oe_i ? dq_i[7:0] : 8'hFF;
			la[n] = lat[11:0];
			ld[n] = d;
			n++;
			if (reset_n_i && bc == 0) begin
				if (wc != 0)
					wc = (d == 8'h30) ? WINM : 0;
				else if (prev == 8'hA0)
					bc = PROG_CYC;
				else if (prev == 8'h55 && d == 8'h10)
					bc = ERASE_CYC;
				else if (prev == 8'h55 && d == 8'h30)
					wc = WINM;
				prev = d;
			end
		end
	// Timer steps on the falling edge, clear of the host's sampling edge
	always @(negedge clock_i)
		if (!reset_n_i) begin
			bc = 0;
			wc = 0;
			rst_seen = 1'b1;
		end else begin
			if (bc != 0)
				bc--;
			if (wc == 1)
				bc = ERASE_CYC;
			if (wc != 0)
				wc--;
		end
endmodule

// File: verif/flsq_host_tb.sv
// Bench for the flash sequencer host: register tasks and command scenarios.
// Assumes the flash model is compiled before this file.
`timescale 1ns/100ps
`include "flsq_defs.svh"
module flsq_host_tb;
	logic        clock_i = 1'b0;
	logic        rstn_i  = 1'b0;
	logic [2:0]  ra      = 3'h0;
	logic [31:0] wd      = 32'h0;
	logic        wr      = 1'b0;
	logic        rd      = 1'b0;
	logic [31:0] rdata;
	logic [19:0] fa;
	logic [15:0] fq;
	logic [15:0] fd;
	logic        doe, fce_n, fwe_n, foe_n, fbyte_n, frst_n, frb;
	int          errors  = 0;
	int          n_tests = 0;
	int          cyc     = 0;
	int          b       = 0;
	logic [31:0] v;
	logic        t;
	flsq_host #(.WIN_CYC(200)) u_dut (.clock_i(clock_i), .rstn_i(rstn_i), .ce_i(1'b1), .reg_addr_i(ra),
		.reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .flash_addr_o(fa),
		.flash_dq_i(fq), .flash_dq_o(fd), .flash_dq_oe_o(doe), .flash_ce_n_o(fce_n),
		.flash_we_n_o(fwe_n), .flash_oe_n_o(foe_n), .flash_byte_n_o(fbyte_n),
		.flash_reset_n_o(frst_n), .ready_busy_i(frb));
	flsq_flash_model #(.WINM(200)) u_fm (.clock_i(clock_i), .addr_i(fa), .dq_i(fd), .dq_oe_i(doe),
		.dq_o(fq), .ce_n_i(fce_n), .we_n_i(fwe_n), .oe_n_i(foe_n), .reset_n_i(frst_n),
		.ready_busy_o(frb));
	initial forever #20 clock_i = ~clock_i;
	// Whole run needs about a thousand cycles
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_tests++;
		if (s !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wreg(input logic [2:0] a, input logic [31:0] d);
		@(posedge clock_i);
		ra <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clock_i);
		wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rreg(input logic [2:0] a);
		@(posedge clock_i);
		ra <= a;
		rd <= 1'b1;
		@(posedge clock_i);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic st(input int bt, input logic e);
		rreg(`FLSQ_REG_STAT);
		chk("status bit", {31'h0, e}, {31'h0, v[bt]});
	endtask
	task automatic pollst(input int bt, input logic e);
		for (int k = 0; k < 400; k++) begin
			rreg(`FLSQ_REG_STAT);
			if (v[bt] === e)
				break;
		end
		chk("status wait", {31'h0, e}, {31'h0, v[bt]});
	endtask
	// Guard cycles after an operation are fixed by the host
	task automatic rdy();
		pollst(`FLSQ_ST_FBUSY, 1'b0);
		repeat (6) @(posedge clock_i);
	endtask
	task automatic op(input logic [3:0] c, input int nw);
		b = u_fm.n;
		wreg(`FLSQ_REG_CMD, {28'h0, c});
		pollst(`FLSQ_ST_CBUSY, 1'b0);
		chk("write count", nw, u_fm.n - b);
	endtask
	task automatic refuse(input logic [3:0] c);
		op(c, 0);
		st(`FLSQ_ST_REFUSED, 1'b1);
	endtask
	task automatic ex(input int i, input logic [11:0] a, input logic [7:0] d);
		chk("flash write", {12'h0, a, d}, {12'h0, u_fm.la[b+i], u_fm.ld[b+i]});
	endtask
	task automatic exd(input int i, input logic [7:0] d);
		chk("flash data", {24'h0, d}, {24'h0, u_fm.ld[b+i]});
	endtask
	initial begin
		repeat (20) @(posedge clock_i);
		rstn_i <= 1'b1;
		repeat (4) @(posedge clock_i);
		rreg(`FLSQ_REG_STAT);
		chk("status reset", 32'h0, v);
		rreg(`FLSQ_REG_CFG);
		chk("cfg reset", 32'h0, v);
		rreg(3'h7);
		chk("unmapped", 32'h0, v);
		$display("test reset done");
		wreg(`FLSQ_REG_ADDR, 32'h123);
		wreg(`FLSQ_REG_DATA, 32'h5A);
		op(`FLSQ_OP_PROG, 4);
		ex(0, 12'h555, 8'hAA);
		ex(1, 12'h2AA, 8'h55);
		ex(2, 12'h555, 8'hA0);
		ex(3, 12'h123, 8'h5A);
		st(`FLSQ_ST_FBUSY, 1'b1);
		refuse(`FLSQ_OP_PROG);
		rdy();
		op(`FLSQ_OP_READ, 0);
		st(`FLSQ_ST_PVALID, 1'b1);
		rreg(`FLSQ_REG_POLL);
		chk("array read", 32'h123, v);
		$display("test word program done");
		wreg(`FLSQ_REG_CFG, 32'h1);
		op(`FLSQ_OP_PROG, 4);
		ex(0, 12'hAAA, 8'hAA);
		ex(2, 12'hAAA, 8'hA0);
		chk("byte pin", 32'h0, {31'h0, fbyte_n});
		rdy();
		wreg(`FLSQ_REG_CFG, 32'h0);
		$display("test byte program done");
		op(`FLSQ_OP_BYPIN, 3);
		ex(2, 12'h555, 8'h20);
		st(`FLSQ_ST_BYPASS, 1'b1);
		op(`FLSQ_OP_PROG, 2);
		exd(0, 8'hA0);
		ex(1, 12'h123, 8'h5A);
		rdy();
		refuse(`FLSQ_OP_CHIP);
		op(`FLSQ_OP_BYPOUT, 2);
		exd(0, 8'h90);
		exd(1, 8'h00);
		st(`FLSQ_ST_BYPASS, 1'b0);
		$display("test bypass done");
		op(`FLSQ_OP_SSIN, 3);
		ex(2, 12'h555, 8'h88);
		st(`FLSQ_ST_SECURE, 1'b1);
		refuse(`FLSQ_OP_BYPIN);
		op(`FLSQ_OP_SSOUT, 4);
		ex(2, 12'h555, 8'h90);
		exd(3, 8'h00);
		st(`FLSQ_ST_SECURE, 1'b0);
		$display("test secured region done");
		op(`FLSQ_OP_CHIP, 6);
		ex(2, 12'h555, 8'h80);
		ex(5, 12'h555, 8'h10);
		refuse(`FLSQ_OP_SECT);
		op(`FLSQ_OP_READ, 0);
		rreg(`FLSQ_REG_POLL);
		t = v[`FLSQ_DQ_TOGGLE];
		op(`FLSQ_OP_READ, 0);
		rreg(`FLSQ_REG_POLL);
		chk("toggle bit", 32'h1, {31'h0, t ^ v[`FLSQ_DQ_TOGGLE]});
		op(`FLSQ_OP_HWRST, 0);
		chk("reset pin seen", 32'h1, {31'h0, u_fm.rst_seen});
		st(`FLSQ_ST_FBUSY, 1'b0);
		st(`FLSQ_ST_SECURE, 1'b0);
		rdy();
		$display("test chip erase done");
		wreg(`FLSQ_REG_ADDR, 32'h400);
		op(`FLSQ_OP_SECT, 6);
		ex(5, 12'h400, 8'h30);
		st(`FLSQ_ST_WINDOW, 1'b1);
		op(`FLSQ_OP_SADD, 1);
		ex(0, 12'h400, 8'h30);
		op(`FLSQ_OP_RESET, 1);
		exd(0, 8'hF0);
		st(`FLSQ_ST_WINDOW, 1'b0);
		chk("window cancelled", 32'h0, u_fm.wc);
		rdy();
		op(`FLSQ_OP_SECT, 6);
		pollst(`FLSQ_ST_WINDOW, 1'b0);
		pollst(`FLSQ_ST_FBUSY, 1'b1);
		refuse(`FLSQ_OP_RESET);
		rdy();
		op(`FLSQ_OP_RESET, 1);
		exd(0, 8'hF0);
		$display("test sector erase done");
		report_and_stop();
	end
endmodule
